// ==== rtl/fsfr_ctrl.sv ====
// Purpose: Host controller issuing flash commands and polling status flags.
// Assumes: One flash on the pins; word mode; inputs synchronous to clk_in.
// Notes:   Completion is judged by the toggle method with a time-limit recheck.
`timescale 1ns/1ps
`include "fsfr_params.svh"
module fsfr_ctrl #(
	parameter int AW = 22,
	parameter int DW = 16,
	parameter logic [31:0] POLL_LIMIT = `FSFR_POLL_LIMIT
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic [2:0] cmd_op_in,
	input wire logic [AW-1:0] cmd_addr_in,
	input wire logic [DW-1:0] cmd_data_in,
	output logic done_out,
	output logic [DW-1:0] rd_data_out,
	output logic [DW-1:0] status_out,
	output logic fail_out,
	output logic not_accepted_out,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic [AW-1:0] addr_out,
	input wire logic [DW-1:0] dq_in,
	output logic [DW-1:0] dq_out,
	output logic dq_oe_out
);
	fsfr_bus_if #(.AW(AW), .DW(DW)) bus ();

	fsfr_pkg::fsfr_state_e state_reg;
	fsfr_pkg::fsfr_op_e op_reg;
	logic [AW-1:0] addr_reg;
	logic [DW-1:0] data_reg;
	logic [2:0] step_reg;
	logic pend_reg;
	logic prev_valid_reg;
	logic [DW-1:0] prev_reg;
	logic [31:0] poll_cnt_reg;
	logic bus_state;
	logic toggling;
	logic tlf_seen;
	logic [AW+DW-1:0] seq_word;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Address and data of one command write, by operation and step.
	function automatic logic [AW+DW-1:0] cmd_word(input fsfr_pkg::fsfr_op_e op, input logic [2:0] step,
		input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [AW-1:0] u1;
		logic [AW-1:0] u2;
		u1 = AW'(`FSFR_UNLOCK1_ADDR);
		u2 = AW'(`FSFR_UNLOCK2_ADDR);
		cmd_word = {u1, DW'(`FSFR_UNLOCK1_DATA)};
		if (op == fsfr_pkg::FSFR_OP_RESET)
			cmd_word = {a, DW'(`FSFR_RESET_DATA)};
		else if (op == fsfr_pkg::FSFR_OP_ADD)
			cmd_word = {a, DW'(`FSFR_SECT_DATA)};
		else if (step == 3'h1 || step == 3'h4)
			cmd_word = {u2, DW'(`FSFR_UNLOCK2_DATA)};
		else if (step == 3'h2)
			cmd_word = {u1, (op == fsfr_pkg::FSFR_OP_PROG) ? DW'(`FSFR_PROG_DATA) : DW'(`FSFR_ERASE_DATA)};
		else if (step == 3'h3)
			cmd_word = (op == fsfr_pkg::FSFR_OP_PROG) ? {a, d} : {u1, DW'(`FSFR_UNLOCK1_DATA)};
		else if (step == 3'h5)
			cmd_word = (op == fsfr_pkg::FSFR_OP_CHIP) ? {u1, DW'(`FSFR_CHIP_DATA)} : {a, DW'(`FSFR_SECT_DATA)};
	endfunction

	// Number of command writes for an operation.
	function automatic logic [2:0] seq_len(input fsfr_pkg::fsfr_op_e op);
		if (op == fsfr_pkg::FSFR_OP_PROG)
			seq_len = `FSFR_PROG_LEN;
		else if (op == fsfr_pkg::FSFR_OP_CHIP || op == fsfr_pkg::FSFR_OP_SECT)
			seq_len = `FSFR_ERASE_LEN;
		else
			seq_len = `FSFR_ONE_LEN;
	endfunction

	// States that own a bus cycle.
	assign bus_state = state_reg inside {fsfr_pkg::FSFR_S_PRECHK, fsfr_pkg::FSFR_S_SEQ,
		fsfr_pkg::FSFR_S_POSTCHK, fsfr_pkg::FSFR_S_POLL, fsfr_pkg::FSFR_S_RECHK,
		fsfr_pkg::FSFR_S_FINAL, fsfr_pkg::FSFR_S_RESET};
	assign seq_word = cmd_word(op_reg, step_reg, addr_reg, data_reg);

	// Toggle and time-limit view of the latest status read against the one before.
	assign toggling = prev_valid_reg && (prev_reg[`FSFR_TOGGLE_BIT] != bus.rdata[`FSFR_TOGGLE_BIT]);
	assign tlf_seen = bus.rdata[`FSFR_TLF_BIT] || prev_reg[`FSFR_TLF_BIT];

	// ----------------------------------------------------------------
	// Bus requests
	// ----------------------------------------------------------------

	// One request at a time in a bus state, each held off until the previous answer.
	assign bus.req = bus_state && !pend_reg;
	assign bus.wr = state_reg inside {fsfr_pkg::FSFR_S_SEQ, fsfr_pkg::FSFR_S_RESET};
	assign bus.addr = (state_reg == fsfr_pkg::FSFR_S_SEQ) ? seq_word[AW+DW-1:DW] : addr_reg;
	assign bus.wdata = (state_reg == fsfr_pkg::FSFR_S_SEQ) ? seq_word[DW-1:0] : DW'(`FSFR_RESET_DATA);

	// Pending flag covers the time between request and answer.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			pend_reg <= 1'b0;
		else if (bus.ack)
			pend_reg <= 1'b0;
		else if (bus.req)
			pend_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------

	// Command issue, status polling and result handling.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state_reg <= fsfr_pkg::FSFR_S_IDLE;
			op_reg <= fsfr_pkg::FSFR_OP_READ;
			addr_reg <= '0;
			data_reg <= '0;
			step_reg <= 3'h0;
			prev_valid_reg <= 1'b0;
			prev_reg <= '0;
			poll_cnt_reg <= 32'h0;
		end
		else
		begin
			unique case (state_reg)
				fsfr_pkg::FSFR_S_IDLE:
				begin
					if (cmd_valid_in)
					begin
						op_reg <= fsfr_pkg::fsfr_op_e'(cmd_op_in);
						addr_reg <= cmd_addr_in;
						data_reg <= cmd_data_in;
						step_reg <= 3'h0;
						prev_valid_reg <= 1'b0;
						poll_cnt_reg <= 32'h0;
						if (cmd_op_in == 3'(fsfr_pkg::FSFR_OP_READ))
							state_reg <= fsfr_pkg::FSFR_S_FINAL;
						else if (cmd_op_in == 3'(fsfr_pkg::FSFR_OP_ADD))
							state_reg <= fsfr_pkg::FSFR_S_PRECHK;
						else
							state_reg <= fsfr_pkg::FSFR_S_SEQ;
					end
				end
				fsfr_pkg::FSFR_S_PRECHK:
				begin
					if (bus.ack)
					begin
						if (bus.rdata[`FSFR_WIN_BIT])
							state_reg <= fsfr_pkg::FSFR_S_DONE;
						else
							state_reg <= fsfr_pkg::FSFR_S_SEQ;
					end
				end
				fsfr_pkg::FSFR_S_SEQ:
				begin
					if (bus.ack)
					begin
						step_reg <= step_reg + 3'h1;
						if (step_reg + 3'h1 == seq_len(op_reg))
						begin
							// Polling starts only after the last write pulse has risen.
							if (op_reg == fsfr_pkg::FSFR_OP_RESET)
								state_reg <= fsfr_pkg::FSFR_S_DONE;
							else if (op_reg == fsfr_pkg::FSFR_OP_ADD)
								state_reg <= fsfr_pkg::FSFR_S_POSTCHK;
							else
								state_reg <= fsfr_pkg::FSFR_S_POLL;
						end
					end
				end
				fsfr_pkg::FSFR_S_POSTCHK:
				begin
					if (bus.ack)
						state_reg <= fsfr_pkg::FSFR_S_DONE;
				end
				fsfr_pkg::FSFR_S_POLL:
				begin
					if (bus.ack)
					begin
						prev_reg <= bus.rdata;
						prev_valid_reg <= 1'b1;
						poll_cnt_reg <= poll_cnt_reg + 32'h1;
						if (prev_valid_reg && !toggling)
							state_reg <= fsfr_pkg::FSFR_S_FINAL;
						else if (toggling && tlf_seen)
						begin
							// Toggle may have stopped just as the limit bit rose: look again.
							prev_valid_reg <= 1'b0;
							state_reg <= fsfr_pkg::FSFR_S_RECHK;
						end
						else if (poll_cnt_reg == POLL_LIMIT)
							state_reg <= fsfr_pkg::FSFR_S_RESET;
					end
				end
				fsfr_pkg::FSFR_S_RECHK:
				begin
					if (bus.ack)
					begin
						prev_reg <= bus.rdata;
						prev_valid_reg <= 1'b1;
						if (prev_valid_reg)
							state_reg <= toggling ? fsfr_pkg::FSFR_S_RESET : fsfr_pkg::FSFR_S_FINAL;
					end
				end
				fsfr_pkg::FSFR_S_FINAL:
				begin
					if (bus.ack)
						state_reg <= fsfr_pkg::FSFR_S_DONE;
				end
				fsfr_pkg::FSFR_S_RESET:
				begin
					if (bus.ack)
						state_reg <= fsfr_pkg::FSFR_S_DONE;
				end
				fsfr_pkg::FSFR_S_DONE:
				begin
					state_reg <= fsfr_pkg::FSFR_S_IDLE;
				end
				default:
				begin
					state_reg <= fsfr_pkg::FSFR_S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Results
	// ----------------------------------------------------------------

	// Array data from the trailing read, and the latest status word.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rd_data_out <= '0;
			status_out <= '0;
		end
		else if (bus.ack && !bus.wr)
		begin
			if (state_reg == fsfr_pkg::FSFR_S_FINAL)
				rd_data_out <= bus.rdata;
			else
				status_out <= bus.rdata;
		end
	end

	// Failure and refusal flags hold until the next command is taken.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			fail_out <= 1'b0;
			not_accepted_out <= 1'b0;
		end
		else if (state_reg == fsfr_pkg::FSFR_S_IDLE && cmd_valid_in)
		begin
			fail_out <= 1'b0;
			not_accepted_out <= 1'b0;
		end
		else if (state_reg == fsfr_pkg::FSFR_S_RESET && bus.ack && op_reg != fsfr_pkg::FSFR_OP_RESET)
			fail_out <= 1'b1;
		else if (bus.ack && bus.rdata[`FSFR_WIN_BIT] &&
			(state_reg == fsfr_pkg::FSFR_S_PRECHK || state_reg == fsfr_pkg::FSFR_S_POSTCHK))
			not_accepted_out <= 1'b1;
	end

	assign cmd_ready_out = (state_reg == fsfr_pkg::FSFR_S_IDLE);
	assign done_out = (state_reg == fsfr_pkg::FSFR_S_DONE);

	// Pin sequencing.
	fsfr_strobe #(.AW(AW), .DW(DW)) u_strobe
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.bus(bus.slave),
		.ce_n_out(ce_n_out),
		.oe_n_out(oe_n_out),
		.we_n_out(we_n_out),
		.addr_out(addr_out),
		.dq_in(dq_in),
		.dq_out(dq_out),
		.dq_oe_out(dq_oe_out)
	);

endmodule // fsfr_ctrl

// ==== rtl/fsfr_params.svh ====
// Purpose: Constants for the flash status-flag polling controller.
// Assumes: 10 MHz clock, flash in word mode.
// Notes:   Times are in ns; cycle counts are derived from them.
`ifndef FSFR_PARAMS_SVH
`define FSFR_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and strobe timing
// ----------------------------------------------------------------
`define FSFR_CLK_NS 100
`define FSFR_T_ACC_NS 70
`define FSFR_T_WP_NS 35
`define FSFR_ACC_CYC ((((`FSFR_T_ACC_NS) + (`FSFR_CLK_NS) - 1) / (`FSFR_CLK_NS)) < 1 ? 1 : \
	(((`FSFR_T_ACC_NS) + (`FSFR_CLK_NS) - 1) / (`FSFR_CLK_NS)))
`define FSFR_WP_CYC ((((`FSFR_T_WP_NS) + (`FSFR_CLK_NS) - 1) / (`FSFR_CLK_NS)) < 1 ? 1 : \
	(((`FSFR_T_WP_NS) + (`FSFR_CLK_NS) - 1) / (`FSFR_CLK_NS)))

// ----------------------------------------------------------------
// Status bit positions in a status read
// ----------------------------------------------------------------
`define FSFR_POLL_BIT 7
`define FSFR_TOGGLE_BIT 6
`define FSFR_TLF_BIT 5
`define FSFR_WIN_BIT 3
`define FSFR_ESTOG_BIT 2

// ----------------------------------------------------------------
// Command cycle addresses and data
// ----------------------------------------------------------------
`define FSFR_UNLOCK1_ADDR 16'h0555
`define FSFR_UNLOCK2_ADDR 16'h02aa
`define FSFR_UNLOCK1_DATA 16'h00aa
`define FSFR_UNLOCK2_DATA 16'h0055
`define FSFR_PROG_DATA 16'h00a0
`define FSFR_ERASE_DATA 16'h0080
`define FSFR_CHIP_DATA 16'h0010
`define FSFR_SECT_DATA 16'h0030
`define FSFR_RESET_DATA 16'h00f0

// ----------------------------------------------------------------
// Sequence lengths and poll limit
// ----------------------------------------------------------------
`define FSFR_PROG_LEN 3'h4
`define FSFR_ERASE_LEN 3'h6
`define FSFR_ONE_LEN 3'h1
`define FSFR_POLL_LIMIT 32'h00ffffff

`endif

// ==== rtl/fsfr_pkg.sv ====
// Purpose: Types shared by the polling controller modules.
// Assumes: Constants come from fsfr_params.svh.
// Notes:   Holds no numbers of its own beyond enum codes.
package fsfr_pkg;

	// User command codes.
	typedef enum logic [2:0]
	{
		FSFR_OP_READ = 3'h0,
		FSFR_OP_PROG = 3'h1,
		FSFR_OP_CHIP = 3'h2,
		FSFR_OP_SECT = 3'h3,
		FSFR_OP_ADD = 3'h4,
		FSFR_OP_RESET = 3'h5
	} fsfr_op_e;

	// Controller states.
	typedef enum logic [3:0]
	{
		FSFR_S_IDLE = 4'h0,
		FSFR_S_PRECHK = 4'h1,
		FSFR_S_SEQ = 4'h2,
		FSFR_S_POSTCHK = 4'h3,
		FSFR_S_POLL = 4'h4,
		FSFR_S_RECHK = 4'h5,
		FSFR_S_FINAL = 4'h6,
		FSFR_S_RESET = 4'h7,
		FSFR_S_DONE = 4'h8
	} fsfr_state_e;

	// Strobe engine states.
	typedef enum logic [1:0]
	{
		FSFR_B_IDLE = 2'h0,
		FSFR_B_SETUP = 2'h1,
		FSFR_B_ACT = 2'h2,
		FSFR_B_RECOV = 2'h3
	} fsfr_bus_e;

endpackage

// ==== rtl/fsfr_bus_if.sv ====
// Purpose: Carries single bus-cycle requests from controller to strobe engine.
// Assumes: One request outstanding at a time.
// Notes:   ack is a one-cycle pulse; rdata is valid with it.
`timescale 1ns/1ps
interface fsfr_bus_if #(parameter int AW = 22, parameter int DW = 16);
	logic req;
	logic wr;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic ack;
	logic [DW-1:0] rdata;
	modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
	modport slave (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// ==== rtl/fsfr_strobe.sv ====
// Purpose: Runs one read or write cycle on the flash strobes.
// Assumes: Flash inputs are synchronous to clk_in.
// Notes:   Address changes only while every strobe is high.
`timescale 1ns/1ps
`include "fsfr_params.svh"
module fsfr_strobe #(parameter int AW = 22, parameter int DW = 16)
(
	input wire logic clk_in,
	input wire logic rst_in,
	fsfr_bus_if.slave bus,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic [AW-1:0] addr_out,
	input wire logic [DW-1:0] dq_in,
	output logic [DW-1:0] dq_out,
	output logic dq_oe_out
);
	fsfr_pkg::fsfr_bus_e state_reg;
	logic [3:0] cnt_reg;
	logic wr_reg;
	logic [DW-1:0] rdata_reg;

	// ----------------------------------------------------------------
	// Cycle sequencing
	// ----------------------------------------------------------------

	// Setup with strobes high, active phase, then a recovery cycle.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state_reg <= fsfr_pkg::FSFR_B_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			addr_out <= '0;
			dq_out <= '0;
		end
		else
		begin
			unique case (state_reg)
				fsfr_pkg::FSFR_B_IDLE:
				begin
					if (bus.req)
					begin
						wr_reg <= bus.wr;
						addr_out <= bus.addr;
						dq_out <= bus.wdata;
						state_reg <= fsfr_pkg::FSFR_B_SETUP;
					end
				end
				fsfr_pkg::FSFR_B_SETUP:
				begin
					cnt_reg <= wr_reg ? 4'(`FSFR_WP_CYC - 1) : 4'(`FSFR_ACC_CYC - 1);
					state_reg <= fsfr_pkg::FSFR_B_ACT;
				end
				fsfr_pkg::FSFR_B_ACT:
				begin
					if (cnt_reg == 4'h0)
						state_reg <= fsfr_pkg::FSFR_B_RECOV;
					else
						cnt_reg <= cnt_reg - 4'h1;
				end
				fsfr_pkg::FSFR_B_RECOV:
				begin
					state_reg <= fsfr_pkg::FSFR_B_IDLE;
				end
			endcase
		end
	end

	// Strobes go low for the active phase only; the rising edge ends the cycle.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ce_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			we_n_out <= 1'b1;
			dq_oe_out <= 1'b0;
		end
		else
		begin
			ce_n_out <= !(state_reg == fsfr_pkg::FSFR_B_SETUP ||
				(state_reg == fsfr_pkg::FSFR_B_ACT && cnt_reg != 4'h0));
			oe_n_out <= !(!wr_reg && (state_reg == fsfr_pkg::FSFR_B_SETUP ||
				(state_reg == fsfr_pkg::FSFR_B_ACT && cnt_reg != 4'h0)));
			we_n_out <= !(wr_reg && (state_reg == fsfr_pkg::FSFR_B_SETUP ||
				(state_reg == fsfr_pkg::FSFR_B_ACT && cnt_reg != 4'h0)));
			// Write data stays driven one cycle past the rising write edge, then recovery lets it go.
			dq_oe_out <= wr_reg && (state_reg == fsfr_pkg::FSFR_B_SETUP || state_reg == fsfr_pkg::FSFR_B_ACT);
		end
	end

	// Read data is taken at the end of the active phase.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rdata_reg <= '0;
		else if (state_reg == fsfr_pkg::FSFR_B_ACT && cnt_reg == 4'h0 && !wr_reg)
			rdata_reg <= dq_in;
	end

	// Answer to the controller.
	assign bus.ack = (state_reg == fsfr_pkg::FSFR_B_RECOV);
	assign bus.rdata = rdata_reg;

endmodule // fsfr_strobe

// ==== test/fsfr_flash_model.sv ====
// Purpose: Behavioural flash device that answers the controller's strobes.
// Assumes: One bank of 16 words, sector is addr[3:2], sector 3 is protected.
// Notes:   Busy time is counted in finished status reads, not in real time.
`timescale 1ns/1ps
module fsfr_flash_model #(parameter int PROG_READS = 3, parameter int ERASE_READS = 6, parameter int PROT_READS = 2)
(
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic [21:0] addr_in,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out
);
	// ----------------------------------------------------------------
	// Array and algorithm state
	// ----------------------------------------------------------------
	logic [15:0] mem [0:15];
	logic [15:0] pdata = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [15:0] stat;
	logic [3:0] paddr = 4'h0;
	logic [3:0] esel = 4'h0;
	logic [2:0] ccount = 3'h0;
	logic [1:0] mode = 2'h0; // Idle, program, erase, locked.
	logic tog = 1'b0;
	logic estog = 1'b0;
	int busy = 0;
	int win = 0;
	// Unknown strobes before the first reset edge count as inactive, so no false strobe end is seen.
	wire rd_on = (ce_n_in === 1'b0) && (oe_n_in === 1'b0) && (we_n_in === 1'b1);
	wire wr_on = (ce_n_in === 1'b0) && (we_n_in === 1'b0) && (oe_n_in === 1'b1);

	// Sector 0 starts blank; the rest hold a recognisable pattern.
	initial
	begin
		for (int i = 0; i < 16; i++)
			mem[i] = (i < 4) ? 16'hffff : (16'ha500 | 16'(i));
	end

	// Commands are taken when the write strobe ends.
	always @(negedge wr_on)
	begin
		if (dq_in[7:0] == 8'hf0)
		begin
			mode = 2'h0;
			ccount = 3'h0;
		end
		else if (mode == 2'h2 && win > 0 && dq_in[7:0] == 8'h30)
			esel[addr_in[3:2]] = 1'b1;
		else if (mode == 2'h0)
		begin
			case (ccount)
				3'h0: ccount = (dq_in[7:0] == 8'haa) ? 3'h1 : 3'h0;
				3'h1: ccount = (dq_in[7:0] == 8'h55) ? 3'h2 : 3'h0;
				3'h2: ccount = (dq_in[7:0] == 8'ha0) ? 3'h3 : ((dq_in[7:0] == 8'h80) ? 3'h4 : 3'h0);
				3'h3:
				begin
					paddr = addr_in[3:0];
					pdata = dq_in;
					mode = (addr_in[3:2] != 2'h3 && mem[addr_in[3:0]] != 16'hffff) ? 2'h3 : 2'h1;
					busy = (addr_in[3:2] == 2'h3) ? PROT_READS : PROG_READS;
					ccount = 3'h0;
				end
				3'h4: ccount = (dq_in[7:0] == 8'haa) ? 3'h5 : 3'h0;
				3'h5: ccount = (dq_in[7:0] == 8'h55) ? 3'h6 : 3'h0;
				default:
				begin
					esel = (dq_in[7:0] == 8'h10) ? 4'hf : (4'h1 << addr_in[3:2]);
					mode = 2'h2;
					win = 2;
					busy = (esel == 4'h8) ? PROT_READS : ERASE_READS;
					ccount = 3'h0;
				end
			endcase
		end
	end

	// A finished read strobe advances the toggle bits and the busy count.
	always @(negedge rd_on)
	begin
		last = (mode == 2'h0) ? mem[addr_in[3:0]] : stat;
		if (mode != 2'h0)
		begin
			tog = !tog;
			if (mode == 2'h2 && esel[addr_in[3:2]])
				estog = !estog;
			if (win > 0)
				win--;
			else if (mode != 2'h3)
			begin
				busy--;
				if (busy == 0)
				begin
					if (mode == 2'h1 && paddr[3:2] != 2'h3)
						mem[paddr] = pdata;
					for (int i = 0; i < 12; i++)
						if (mode == 2'h2 && esel[i / 4]) mem[i] = 16'hffff;
					mode = 2'h0;
				end
			end
		end
	end

	// Status word of a busy bank; in program mode the polling bit turns true on the last busy read.
	always_comb
	begin
		stat = 16'h0000;
		stat[7] = (mode == 2'h2) ? 1'b0 : ((busy == 1) ? pdata[7] : !pdata[7]);
		stat[6] = tog;
		stat[5] = (mode == 2'h3);
		stat[3] = (mode == 2'h2 && win == 0);
		stat[2] = (mode == 2'h2) ? estog : 1'b1;
	end

	// Idle reads give the array; released lines show the inverse of the last word.
	assign dq_out = !rd_on ? ~last : ((mode == 2'h0) ? mem[addr_in[3:0]] : stat);
endmodule // fsfr_flash_model

// ==== test/fsfr_ctrl_monitor.sv ====
// Purpose: Pin-level checks on the flash polling controller.
// Assumes: Bound to fsfr_ctrl; one clock domain.
// Notes:   Small counters remember how recently a reset write or window flag was seen.
`timescale 1ns/1ps
module fsfr_ctrl_monitor #(parameter int AW = 22, parameter int DW = 16, parameter logic [31:0] POLL_LIMIT = 32'h00ffffff)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic cmd_ready_out,
	input wire logic fail_out,
	input wire logic not_accepted_out,
	input wire logic ce_n_out,
	input wire logic oe_n_out,
	input wire logic we_n_out,
	input wire logic [AW-1:0] addr_out,
	input wire logic [DW-1:0] dq_in,
	input wire logic [DW-1:0] dq_out,
	input wire logic dq_oe_out
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic [3:0] since_rst_wr;
	logic [3:0] since_win_hi;
	default clocking mon_cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Cycles since a reset command was written, saturating.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			since_rst_wr <= 4'hf;
		else if (!we_n_out && dq_out[7:0] == 8'hf0)
			since_rst_wr <= 4'h0;
		else if (since_rst_wr != 4'hf)
			since_rst_wr <= since_rst_wr + 4'h1;
	end

	// Cycles since a read showed the erase-window bit high, saturating.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			since_win_hi <= 4'hf;
		else if (!oe_n_out && !ce_n_out && dq_in[3])
			since_win_hi <= 4'h0;
		else if (since_win_hi != 4'hf)
			since_win_hi <= since_win_hi + 4'h1;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_addr_when_idle: assert property (!$stable(addr_out) |-> ce_n_out && oe_n_out && $past(oe_n_out))
		else $error("address moved while a strobe was active");
	a_idle_quiet: assert property (cmd_ready_out |-> ce_n_out && oe_n_out && we_n_out && !dq_oe_out)
		else $error("strobes active while idle");
	a_write_drives: assert property ($fell(we_n_out) |-> dq_oe_out && !ce_n_out && oe_n_out)
		else $error("write pulse without driven data");
	a_write_ends: assert property ($fell(we_n_out) |-> ##[1:4] (we_n_out && ce_n_out))
		else $error("write pulse did not end");
	a_read_released: assert property ($fell(oe_n_out) |-> !dq_oe_out && !ce_n_out && we_n_out)
		else $error("read while data lines driven");
	a_read_ends: assert property ($fell(oe_n_out) |-> ##[1:4] (oe_n_out && ce_n_out))
		else $error("read strobe did not complete");
	a_fail_by_reset: assert property ($rose(fail_out) |-> since_rst_wr < 4'h8)
		else $error("failure flagged without reset write");
	a_refusal_by_window: assert property ($rose(not_accepted_out) |-> since_win_hi < 4'ha)
		else $error("refusal flagged without window bit");
endmodule // fsfr_ctrl_monitor

bind fsfr_ctrl fsfr_ctrl_monitor #(.AW(AW), .DW(DW), .POLL_LIMIT(POLL_LIMIT)) fsfr_ctrl_monitor_i (
	.clk_in(clk_in), .rst_in(rst_in), .cmd_ready_out(cmd_ready_out), .fail_out(fail_out),
	.not_accepted_out(not_accepted_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out),
	.addr_out(addr_out), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out)
);

// ==== test/tb.sv ====
// Purpose: Command-level testbench for the flash polling controller.
// Assumes: Flash model on the pins; poll limit shortened to 64 reads.
// Notes:   Each command waits for done_out, then flags and data are compared.
`timescale 1ns/1ps
module tb;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic cmd_valid_in = 1'b0;
	logic [2:0] cmd_op_in = 3'h0;
	logic [21:0] cmd_addr_in = 22'h000000;
	logic [15:0] cmd_data_in = 16'h0000;
	logic cmd_ready_out, done_out, fail_out, not_accepted_out, ce_n, oe_n, we_n, dq_oe;
	logic [15:0] rd_data_out, status_out, dq_to_ctrl, dq_to_flash;
	logic [21:0] addr;
	int err_count = 0;
	int checks_done = 0;

	fsfr_ctrl #(.POLL_LIMIT(32'h00000040)) fsfr_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
		.cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .done_out(done_out), .rd_data_out(rd_data_out),
		.status_out(status_out), .fail_out(fail_out), .not_accepted_out(not_accepted_out), .ce_n_out(ce_n),
		.oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr), .dq_in(dq_to_ctrl), .dq_out(dq_to_flash),
		.dq_oe_out(dq_oe));
	fsfr_flash_model fsfr_flash_model_i (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr),
		.dq_in(dq_to_flash), .dq_out(dq_to_ctrl));

	// Free-running 10 MHz clock.
	initial
	begin
		forever #50 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Present one command for one edge, then wait for its done pulse.
	task automatic do_cmd(input logic [2:0] op, input logic [21:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		cmd_valid_in <= 1'b1;
		cmd_op_in <= op;
		cmd_addr_in <= a;
		cmd_data_in <= d;
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (done_out !== 1'b1 && n < 4000);
		if (n >= 4000)
		begin
			err_count++;
			report_and_stop;
		end
	endtask

	task automatic rd_chk(input logic [21:0] a, input logic [15:0] exp);
		do_cmd(fsfr_pkg::FSFR_OP_READ, a, 16'h0000);
		chk16(rd_data_out, exp);
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Cuts a hang short; the tests need well under 5000 cycles.
	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		report_and_stop;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		rd_chk(22'h000005, 16'ha505);
		do_cmd(fsfr_pkg::FSFR_OP_PROG, 22'h000001, 16'h1234);
		chk16(rd_data_out, 16'h1234);
		chk1(fail_out, 1'b0);
		rd_chk(22'h000001, 16'h1234);
		do_cmd(fsfr_pkg::FSFR_OP_PROG, 22'h00000d, 16'h0000);
		chk1(fail_out, 1'b0);
		rd_chk(22'h00000d, 16'ha50d);
		do_cmd(fsfr_pkg::FSFR_OP_PROG, 22'h000001, 16'h0000);
		chk1(fail_out, 1'b1);
		chk1(status_out[5], 1'b1);
		chk1(status_out[7], 1'b1);
		rd_chk(22'h000001, 16'h1234);
		do_cmd(fsfr_pkg::FSFR_OP_RESET, 22'h000000, 16'h0000);
		chk1(fail_out, 1'b0);
		do_cmd(fsfr_pkg::FSFR_OP_SECT, 22'h000004, 16'h0000);
		chk1(fail_out, 1'b0);
		rd_chk(22'h000006, 16'hffff);
		do_cmd(fsfr_pkg::FSFR_OP_ADD, 22'h000004, 16'h0000);
		chk1(not_accepted_out, 1'b1);
		do_cmd(fsfr_pkg::FSFR_OP_CHIP, 22'h000000, 16'h0000);
		rd_chk(22'h000009, 16'hffff);
		rd_chk(22'h00000e, 16'ha50e);
		do_cmd(fsfr_pkg::FSFR_OP_SECT, 22'h00000c, 16'h0000);
		chk1(fail_out, 1'b0);
		rd_chk(22'h00000c, 16'ha50c);
		report_and_stop;
	end
endmodule // tb
